// ==== design/pmc_cmd_port.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Access opens with start and address byte
// - Write: address high, low, length, data
// - Read: header, repeated start, incrementing data
// - Stretch clock while read data fetched
// - Command at fixed address, opcode, 0..63
// - Status register holds last access outcome
// - Config writes only while stopped
// - Each config write committed to store alone
// - Monitoring area readable always, never written
// - Rail voltage read measured live
// - 32 signed millivolt rails from base
// - Data accesses of 1 to 64 bytes allowed
// - Reserved opcodes do nothing
// - Start opcode only when stopped
// - Stop opcode ignored while stopped
// - Low margin on channel when started
// - Nominal margin on channel when started
// - High margin on channel when started
// - Reinitialise opcode only when stopped
// - Seven-bit addressing, 100/400 kbps link
// - Thresholds as low/high byte pairs
module pmc_cmd_port
  import pmc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        link_clk_i,
  input  wire logic        lk_start_i,
  input  wire logic        lk_stop_i,
  input  wire logic        lk_rx_valid_i,
  input  wire logic [7:0]  lk_rx_byte_i,
  input  wire logic        lk_tx_req_i,
  output logic             lk_stretch_o,
  output logic             lk_ack_o,
  output logic [7:0]       lk_tx_byte_o,
  input  wire logic [6:0]  slave_addr_i,
  input  wire logic        pm_stopped_i,
  input  wire logic        pm_started_i,
  output logic             st_wr_o,
  output logic             st_rd_o,
  output logic [15:0]      st_addr_o,
  output logic [7:0]       st_wdata_o,
  input  wire logic [7:0]  st_rdata_i,
  input  wire logic        st_done_i,
  output logic             mv_req_o,
  output logic [4:0]       mv_rail_o,
  input  wire logic [15:0] mv_value_i,
  input  wire logic        mv_done_i,
  output logic             cmd_start_o,
  output logic             cmd_stop_o,
  output logic             cmd_init_o,
  output logic             cmd_margin_o,
  output logic [1:0]       margin_level_o,
  output logic [7:0]       margin_chan_o,
  output logic [7:0]       status_o
);

  pmc_sys_s s_reg;
  pmc_sys_s s_next;
  pmc_lnk_s l_reg;
  pmc_lnk_s l_next;

  // Keep the first error of an access
  function automatic logic [7:0] keep_err(input logic [7:0] cur, input logic [7:0] nw);
    keep_err = (cur == ST_OK) ? nw : cur;
  endfunction : keep_err

  function automatic logic in_cfg(input logic [15:0] a);
    in_cfg = (a < MON_BASE);
  endfunction : in_cfg

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: one event in flight, clock held low on received or requested bytes until answered
  always_comb
  begin
    l_next     = l_reg;
    l_next.rs1 = rst_n_i;
    l_next.rs2 = l_reg.rs1;
    if (l_reg.rs2)
    begin
      l_next.ak_s1 = s_reg.ack_tgl;
      l_next.ak_s2 = l_reg.ak_s1;
      if (l_reg.pend)
      begin
        if (l_reg.ak_s2 != l_reg.ak_seen)
        begin
          l_next.ak_seen = l_reg.ak_s2;
          l_next.pend    = 1'b0;
          l_next.stretch = 1'b0;
          l_next.ack     = s_reg.resp_ack;
          l_next.tx_byte = s_reg.resp_byte;
        end
      end
      else if (lk_stop_i || lk_start_i || lk_rx_valid_i || lk_tx_req_i)
      begin
        l_next.ev_kind = lk_stop_i ? EV_STOP : lk_start_i ? EV_START : lk_rx_valid_i ? EV_RX : EV_TX;
        l_next.ev_byte = lk_rx_byte_i;
        l_next.ev_tgl  = ~l_reg.ev_tgl;
        l_next.pend    = 1'b1;
        l_next.stretch = lk_rx_valid_i || lk_tx_req_i;
      end
    end
    else
    begin
      l_next     = LNK_RST;
      l_next.rs1 = rst_n_i;
      l_next.rs2 = l_reg.rs1;
    end
  end

  always_ff @(posedge link_clk_i)
  begin
    l_reg <= l_next;
  end

  assign lk_stretch_o = l_reg.stretch;
  assign lk_ack_o     = l_reg.ack;
  assign lk_tx_byte_o = l_reg.tx_byte;

  sequence s_held;
    lk_stretch_o && (l_reg.ak_s2 == l_reg.ak_seen);
  endsequence

  a_stretch_hold: assert property (@(posedge link_clk_i) disable iff (!l_reg.rs2) s_held |=> lk_stretch_o)
    else $error("stretch released before answer");
  a_stretch_take: assert property (@(posedge link_clk_i) disable iff (!l_reg.rs2)
    (lk_tx_req_i && !l_reg.pend && !lk_stop_i && !lk_start_i) |=> lk_stretch_o && l_reg.pend)
    else $error("read request not stretched");

  ////////////////////////////////////////////////////////////////////////////
  // System domain: protocol interpreter
  always_comb
  begin
    logic       ev_new;
    logic       answer;
    logic       do_exec;
    logic       has_chan;
    logic [7:0] b;
    logic [7:0] op_v;
    logic [7:0] chan_v;
    ev_new   = 1'b0;
    answer   = 1'b0;
    do_exec  = 1'b0;
    has_chan = 1'b0;
    b        = l_reg.ev_byte;
    op_v     = s_reg.opcode;
    chan_v   = s_reg.chan;

    s_next            = s_reg;
    s_next.ev_s1      = l_reg.ev_tgl;
    s_next.ev_s2      = s_reg.ev_s1;
    s_next.st_wr      = 1'b0;
    s_next.st_rd      = 1'b0;
    s_next.mv_req     = 1'b0;
    s_next.cmd_start  = 1'b0;
    s_next.cmd_stop   = 1'b0;
    s_next.cmd_init   = 1'b0;
    s_next.cmd_margin = 1'b0;

    if (s_reg.wt != W_NONE)
    begin
      if (s_reg.wt == W_STORE && st_done_i)
      begin
        s_next.resp_byte = st_rdata_i;
        s_next.wt        = W_NONE;
        answer           = 1'b1;
      end
      else if (s_reg.wt == W_MEAS && mv_done_i)
      begin
        s_next.resp_byte = s_reg.hi_sel ? mv_value_i[15:8] : mv_value_i[7:0];
        s_next.wt        = W_NONE;
        answer           = 1'b1;
      end
    end
    else if (s_reg.ev_s2 != s_reg.ev_seen)
    begin
      ev_new           = 1'b1;
      answer           = 1'b1;
      s_next.ev_seen   = s_reg.ev_s2;
      s_next.resp_ack  = 1'b0;
      s_next.resp_byte = FILL_BYTE;
      unique case (l_reg.ev_kind)
        EV_START:
        begin
          if (s_reg.st == ST_IDLE)
          begin
            s_next.ours   = 1'b0;
            s_next.len_ok = 1'b0;
            s_next.err    = ST_OK;
          end
          s_next.st = ST_SLA;
        end
        EV_STOP:
        begin
          if (s_reg.ours)
          begin
            if (s_reg.st == ST_WDAT && s_reg.len_ok && s_reg.len_cnt != 8'h00)
              s_next.status = keep_err(s_reg.err, ST_SHORT);
            else
              s_next.status = s_reg.err;
          end
          s_next.st     = ST_IDLE;
          s_next.ours   = 1'b0;
          s_next.len_ok = 1'b0;
        end
        EV_RX:
        begin
          s_next.resp_ack = 1'b1;
          case (s_reg.st)
            ST_SLA:
            begin
              if (b[7:1] == slave_addr_i)
              begin
                s_next.ours = 1'b1;
                if (b[0])
                  s_next.st = ST_RDAT;
                else
                begin
                  s_next.st     = ST_AHI;
                  s_next.len_ok = 1'b0;
                end
              end
              else
              begin
                s_next.resp_ack = 1'b0;
                s_next.st       = ST_SKIP;
              end
            end
            ST_AHI:
            begin
              s_next.addr[15:8] = b;
              s_next.st         = ST_ALO;
            end
            ST_ALO:
            begin
              s_next.addr[7:0] = b;
              s_next.st        = ST_LEN;
            end
            ST_LEN:
            begin
              s_next.is_cmd  = (s_reg.addr == CMD_ADDR);
              s_next.len_cnt = b;
              s_next.first   = 1'b1;
              if (s_reg.addr == CMD_ADDR)
                s_next.len_ok = (b <= CMD_LEN_MAX);
              else
                s_next.len_ok = (b >= LEN_MIN) && (b <= LEN_MAX);
              if (!s_next.len_ok)
                s_next.err = keep_err(s_reg.err, ST_BAD_LEN);
              s_next.st = (s_reg.addr == CMD_ADDR) ? ST_OPC : ST_WDAT;
            end
            ST_OPC:
            begin
              s_next.opcode = b;
              op_v          = b;
              s_next.st     = ST_WDAT;
              do_exec       = s_reg.len_ok && (s_reg.len_cnt == 8'h00);
            end
            ST_WDAT:
            begin
              if (!s_reg.len_ok)
                s_next.err = keep_err(s_reg.err, ST_BAD_LEN);
              else if (s_reg.len_cnt == 8'h00)
                s_next.err = keep_err(s_reg.err, ST_OVERRUN);
              else
              begin
                s_next.len_cnt = s_reg.len_cnt - CNT_STEP;
                if (s_reg.is_cmd)
                begin
                  if (s_reg.first)
                  begin
                    s_next.chan = b;
                    chan_v      = b;
                  end
                  s_next.first = 1'b0;
                  has_chan     = 1'b1;
                  do_exec      = (s_reg.len_cnt == CNT_STEP);
                end
                else
                begin
                  s_next.addr = s_reg.addr + ADDR_STEP;
                  if (!in_cfg(s_reg.addr))
                    s_next.err = keep_err(s_reg.err, ST_READ_ONLY);
                  else if (!pm_stopped_i)
                    s_next.err = keep_err(s_reg.err, ST_IGNORED);
                  else
                  begin
                    s_next.st_wr    = 1'b1;
                    s_next.st_addr  = s_reg.addr;
                    s_next.st_wdata = b;
                    s_next.wt       = W_STORE;
                    answer          = 1'b0;
                  end
                end
              end
            end
            ST_IDLE, ST_SKIP, ST_RDAT:
              s_next.resp_ack = 1'b0;
            default:
            begin
              s_next.resp_ack = 1'b0;
              s_next.st       = ST_IDLE;
            end
          endcase
        end
        EV_TX:
        begin
          if (s_reg.st == ST_RDAT && s_reg.ours)
          begin
            if (!s_reg.len_ok || s_reg.len_cnt == 8'h00)
              s_next.err = keep_err(s_reg.err, s_reg.len_ok ? ST_OVERRUN : ST_BAD_LEN);
            else
            begin
              s_next.len_cnt = s_reg.len_cnt - CNT_STEP;
              s_next.addr    = s_reg.addr + ADDR_STEP;
              s_next.st_addr = s_reg.addr;
              if (in_cfg(s_reg.addr))
              begin
                s_next.st_rd = 1'b1;
                s_next.wt    = W_STORE;
                answer       = 1'b0;
              end
              else if (s_reg.addr < MON_END)
              begin
                s_next.mv_req  = 1'b1;
                s_next.mv_rail = s_reg.addr[5:1];
                s_next.hi_sel  = s_reg.addr[0];
                s_next.wt      = W_MEAS;
                answer         = 1'b0;
              end
              else if (s_reg.addr == STATUS_ADDR)
                s_next.resp_byte = s_reg.status;
              else
                s_next.resp_byte = UNMAP_BYTE;
            end
          end
        end
      endcase
    end

    // Opcode execution with state gating
    if (ev_new && do_exec)
    begin
      case (op_v)
        OP_START:
          if (pm_stopped_i) s_next.cmd_start = 1'b1;
          else s_next.err = keep_err(s_reg.err, ST_IGNORED);
        OP_STOP:
          if (!pm_stopped_i) s_next.cmd_stop = 1'b1;
          else s_next.err = keep_err(s_reg.err, ST_IGNORED);
        OP_INIT:
          if (pm_stopped_i) s_next.cmd_init = 1'b1;
          else s_next.err = keep_err(s_reg.err, ST_IGNORED);
        OP_MLOW, OP_MNOM, OP_MHIGH:
        begin
          if (!has_chan)
            s_next.err = keep_err(s_reg.err, ST_BAD_LEN);
          else if (!pm_started_i)
            s_next.err = keep_err(s_reg.err, ST_IGNORED);
          else
          begin
            s_next.cmd_margin = 1'b1;
            s_next.mchan      = chan_v;
            s_next.mlevel     = (op_v == OP_MLOW) ? MRG_LOW : (op_v == OP_MHIGH) ? MRG_HIGH : MRG_NOMINAL;
          end
        end
        default: ;
      endcase
    end

    if (answer)
      s_next.ack_tgl = ~s_reg.ack_tgl;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      s_reg <= SYS_RST;
    else
      s_reg <= s_next;
  end

  assign st_wr_o        = s_reg.st_wr;
  assign st_rd_o        = s_reg.st_rd;
  assign st_addr_o      = s_reg.st_addr;
  assign st_wdata_o     = s_reg.st_wdata;
  assign mv_req_o       = s_reg.mv_req;
  assign mv_rail_o      = s_reg.mv_rail;
  assign cmd_start_o    = s_reg.cmd_start;
  assign cmd_stop_o     = s_reg.cmd_stop;
  assign cmd_init_o     = s_reg.cmd_init;
  assign cmd_margin_o   = s_reg.cmd_margin;
  assign margin_level_o = s_reg.mlevel;
  assign margin_chan_o  = s_reg.mchan;
  assign status_o       = s_reg.status;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_commit_wait;
    !st_wr_o && (s_reg.wt == W_STORE);
  endsequence

  a_cfg_wr_stopped: assert property (@(posedge clk_i) disable iff (!rst_n_i) st_wr_o |-> $past(pm_stopped_i))
    else $error("config write while not stopped");
  a_commit_single: assert property (@(posedge clk_i) disable iff (!rst_n_i) st_wr_o |=> s_commit_wait)
    else $error("store write not a single pulse");
  a_len_gate_wr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    st_wr_o |-> $past(s_reg.len_ok) && ($past(s_reg.len_cnt) != 8'h00))
    else $error("write outside accepted length");
  a_start_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i) cmd_start_o |-> $past(pm_stopped_i))
    else $error("start issued while not stopped");
  a_stop_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i) cmd_stop_o |-> !$past(pm_stopped_i))
    else $error("stop issued while stopped");
  a_margin_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cmd_margin_o |-> $past(pm_started_i) && (margin_level_o != 2'h3))
    else $error("margin issued while not started");
  a_init_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i) cmd_init_o |-> $past(pm_stopped_i))
    else $error("init issued while not stopped");
  a_rail_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mv_req_o |-> (mv_rail_o == st_addr_o[5:1]) && (st_addr_o[15:6] == MON_BASE[15:6]))
    else $error("rail number does not match address");
  a_live_answer: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.wt == W_MEAS && mv_done_i) |=> (s_reg.ack_tgl != $past(s_reg.ack_tgl)) && (s_reg.wt == W_NONE))
    else $error("measured value not answered");
  a_status_on_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $changed(status_o) |-> $past(s_reg.ev_s2 != s_reg.ev_seen) && ($past(l_reg.ev_kind) == EV_STOP))
    else $error("status changed outside stop");

endmodule : pmc_cmd_port

// ==== dv/pmc_cmd_port_test.sv ====
`timescale 1ns/1ps
module pmc_cmd_port_test;
  import pmc_pkg::*;
  localparam logic [6:0] SA = 7'h2A;
  logic        clk_i = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        lk_start, lk_stop, lk_rxv, lk_txr, lk_stretch, lk_ack;
  logic [7:0]  lk_rxb, lk_txb, st_wdata, status;
  logic        pm_stopped = 1'b1;
  logic        pm_started = 1'b0;
  logic        st_wr, st_rd, mv_req, c_start, c_stop, c_init, c_mrg;
  logic        st_done = 1'b0;
  logic        mv_done = 1'b0;
  logic [15:0] st_addr, mv_value = 16'h0000;
  logic [7:0]  st_rdata = 8'h00;
  logic [7:0]  m_chan;
  logic [4:0]  mv_rail;
  logic [1:0]  m_lvl;
  logic [23:0] wq[$];
  logic [15:0] pc = 16'h0000;
  logic [2:0]  sd = 3'h0;
  logic [2:0]  md = 3'h0;
  logic [7:0]  q[$];
  logic        ak;
  int          error_cnt = 0;
  int          compares = 0;

  always #5 clk_i = ~clk_i;
  always #24 link_clk = ~link_clk;

  pmc_cmd_port i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk),
    .lk_start_i(lk_start), .lk_stop_i(lk_stop), .lk_rx_valid_i(lk_rxv), .lk_rx_byte_i(lk_rxb),
    .lk_tx_req_i(lk_txr), .lk_stretch_o(lk_stretch), .lk_ack_o(lk_ack), .lk_tx_byte_o(lk_txb),
    .slave_addr_i(SA), .pm_stopped_i(pm_stopped), .pm_started_i(pm_started),
    .st_wr_o(st_wr), .st_rd_o(st_rd), .st_addr_o(st_addr), .st_wdata_o(st_wdata),
    .st_rdata_i(st_rdata), .st_done_i(st_done), .mv_req_o(mv_req), .mv_rail_o(mv_rail),
    .mv_value_i(mv_value), .mv_done_i(mv_done), .cmd_start_o(c_start), .cmd_stop_o(c_stop),
    .cmd_init_o(c_init), .cmd_margin_o(c_mrg), .margin_level_o(m_lvl),
    .margin_chan_o(m_chan), .status_o(status));

  pmc_host_model i_host (.lclk_i(link_clk), .stretch_i(lk_stretch), .ack_i(lk_ack),
    .txb_i(lk_txb), .start_o(lk_start), .stop_o(lk_stop), .rxv_o(lk_rxv), .rxb_o(lk_rxb),
    .txr_o(lk_txr));

  //////////////////////////////
  // Store and measure responders, data garbled outside done
  always @(negedge clk_i)
  begin
    st_done = (sd == 3'h1);
    mv_done = (md == 3'h1);
    if (st_wr)
      wq.push_back({st_addr, st_wdata});
    pc += {3'h0, c_mrg, 3'h0, c_init, 3'h0, c_stop, 3'h0, c_start};
    sd = (st_wr || st_rd) ? 3'h4 : sd - 3'(sd != 3'h0);
    md = mv_req ? 3'h3 : md - 3'(md != 3'h0);
    st_rdata = st_addr[7:0] ^ (st_done ? 8'h5A : 8'hA5);
    mv_value = {3'h5, mv_rail, 3'h2, mv_rail} ^ {16{!mv_done}};
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic mode(input logic s);
    @(negedge clk_i);
    pm_stopped = s;
    pm_started = !s;
  endtask : mode
  task automatic print_verdict;
    error_cnt += i_host.hangs;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  //////////////////////////////
  task automatic t_cfg;
    mode(1'b1);
    wq = {};
    i_host.wr(SA, 16'h0010, 8'h02, {8'hA5, 8'h3C}, ak);
    chk(24'(ak), 24'h1);
    chk(24'(wq.size()), 24'h2);
    chk(wq[0], 24'h0010A5);
    chk(wq[1], 24'h00113C);
    chk(24'(status), 24'(ST_OK));
    mode(1'b0);
    i_host.wr(SA, 16'h0012, 8'h01, {8'h77}, ak);
    chk(24'(wq.size()), 24'h2);
    chk(24'(status), 24'(ST_IGNORED));
    i_host.wr(SA ^ 7'h01, 16'h0012, 8'h01, {8'h77}, ak);
    chk(24'(ak), 24'h0);
  endtask : t_cfg
  task automatic t_rd;
    i_host.rd(SA, 16'h0020, 8'h02, q);
    chk(24'(q[0]), 24'h7A);
    chk(24'(q[1]), 24'h7B);
    i_host.rd(SA, MON_BASE + 16'h003E, 8'h02, q);
    chk(24'(q[0]), 24'h5F);
    chk(24'(q[1]), 24'hBF);
    i_host.wr(SA, MON_BASE, 8'h01, {8'h12}, ak);
    chk(24'(wq.size()), 24'h2);
    chk(24'(status), 24'(ST_READ_ONLY));
  endtask : t_rd
  task automatic t_len;
    logic [7:0] bad [2] = '{8'h00, 8'h41};
    logic [7:0] d[$];
    mode(1'b1);
    wq = {};
    foreach (bad[i])
    begin
      i_host.wr(SA, 16'h0030, bad[i], {8'h55}, ak);
      chk(24'(wq.size()), 24'h0);
      chk(24'(status), 24'(ST_BAD_LEN));
    end
    i_host.rd(SA, STATUS_ADDR, 8'h01, q);
    chk(24'(q[0]), 24'(ST_BAD_LEN));
    for (int i = 0; i < 64; i++)
      d.push_back(8'(i));
    i_host.wr(SA, 16'h0031, LEN_MAX, d, ak);
    chk(24'(wq.size()), 24'h40);
    chk(wq[63], 24'h00703F);
    i_host.wr(SA, 16'h0080, 8'h02, {8'h01}, ak);
    chk(24'(status), 24'(ST_SHORT));
    i_host.wr(SA, 16'h0080, 8'h01, {8'h01, 8'h02}, ak);
    chk(24'(status), 24'(ST_OVERRUN));
    chk(24'(wq.size()), 24'h42);
  endtask : t_len
  task automatic t_cmd;
    logic [7:0]  op [12] = '{8'h01, 8'h01, 8'h06, 8'h02, 8'h03, 8'h04, 8'h05, 8'h00, 8'h07, 8'h02, 8'h04,
                             8'h06};
    logic [11:0] stp = 12'h785;
    logic [11:0] ign = 12'hE02;
    logic [15:0] ex [12] = '{16'h0001, 16'h0000, 16'h0100, 16'h0010, 16'h1000, 16'h1000,
                             16'h1000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [7:0]  d[$];
    for (int i = 0; i < 12; i++)
    begin
      mode(stp[i]);
      pc = 16'h0000;
      d = {op[i]};
      if (op[i] inside {OP_MLOW, OP_MNOM, OP_MHIGH})
        d.push_back(8'h10 + 8'(i));
      i_host.wr(SA, CMD_ADDR, 8'(d.size() - 1), d, ak);
      chk(24'(pc), 24'(ex[i]));
      chk(24'(status), ign[i] ? 24'(ST_IGNORED) : 24'(ST_OK));
      if (ex[i][12])
      begin
        chk(24'(m_lvl), 24'(op[i] - 8'h03));
        chk(24'(m_chan), 24'(8'h10 + 8'(i)));
      end
    end
  endtask : t_cmd

  initial
  begin
    repeat (20) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (10) @(negedge link_clk);
    t_cfg;
    t_rd;
    t_len;
    t_cmd;
    print_verdict;
  end
  initial
  begin
    #900000;
    error_cnt++;
    print_verdict;
  end
endmodule : pmc_cmd_port_test

// ==== dv/pmc_host_model.sv ====
`timescale 1ns/1ps
module pmc_host_model
  import pmc_pkg::*;
(
  input  wire logic       lclk_i,
  input  wire logic       stretch_i,
  input  wire logic       ack_i,
  input  wire logic [7:0] txb_i,
  output logic            start_o,
  output logic            stop_o,
  output logic            rxv_o,
  output logic [7:0]      rxb_o,
  output logic            txr_o
);
  int hangs = 0;
  initial
  begin
    {start_o, stop_o, rxv_o, txr_o} = 4'h0;
    rxb_o = 8'hFF;
  end
  //////////////////////////////
  // Bounded wait for the answer
  task automatic settle(input int n);
    repeat (n) @(negedge lclk_i);
    for (int i = 0; i < 400 && stretch_i; i++)
      @(negedge lclk_i);
    // Answer never came: counted as a mismatch at the verdict
    if (stretch_i)
      hangs++;
  endtask : settle
  task automatic cond(input logic s);
    @(negedge lclk_i);
    start_o = s;
    stop_o = !s;
    @(negedge lclk_i);
    start_o = 1'b0;
    stop_o = 1'b0;
    settle(8);
  endtask : cond
  task automatic put(input logic [7:0] b, output logic a);
    @(negedge lclk_i);
    rxv_o = 1'b1;
    rxb_o = b;
    @(negedge lclk_i);
    rxv_o = 1'b0;
    rxb_o = ~b;
    settle(2);
    a = ack_i;
  endtask : put
  task automatic get(output logic [7:0] b);
    @(negedge lclk_i);
    txr_o = 1'b1;
    @(negedge lclk_i);
    txr_o = 1'b0;
    settle(2);
    b = txb_i;
  endtask : get
  task automatic wr(input logic [6:0] sa, input logic [15:0] a, input logic [7:0] n,
                    input logic [7:0] d[$], output logic ak);
    logic x;
    cond(1'b1);
    put({sa, 1'b0}, ak);
    put(a[15:8], x);
    put(a[7:0], x);
    put(n, x);
    foreach (d[i])
      put(d[i], x);
    cond(1'b0);
  endtask : wr
  task automatic rd(input logic [6:0] sa, input logic [15:0] a, input logic [7:0] n,
                    output logic [7:0] q[$]);
    logic       x;
    logic [7:0] b;
    cond(1'b1);
    put({sa, 1'b0}, x);
    put(a[15:8], x);
    put(a[7:0], x);
    put(n, x);
    cond(1'b1);
    put({sa, 1'b1}, x);
    q = {};
    repeat (n)
    begin
      get(b);
      q.push_back(b);
    end
    cond(1'b0);
  endtask : rd
endmodule : pmc_host_model

// ==== pkg/pmc_pkg.sv ====
package pmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register space layout
  localparam logic [15:0] MON_BASE    = 16'h0D00;
  localparam logic [15:0] MON_END     = 16'h0D40;
  localparam logic [15:0] CMD_ADDR    = 16'h8000;
  localparam logic [15:0] STATUS_ADDR = 16'h8001;
  localparam logic [15:0] ADDR_STEP   = 16'h0001;

  // Length limits
  localparam logic [7:0]  LEN_MIN     = 8'h01;
  localparam logic [7:0]  LEN_MAX     = 8'h40;
  localparam logic [7:0]  CMD_LEN_MAX = 8'h3F;
  localparam logic [7:0]  CNT_STEP    = 8'h01;

  // Read fill values
  localparam logic [7:0]  FILL_BYTE   = 8'hFF;
  localparam logic [7:0]  UNMAP_BYTE  = 8'h00;

  // Command opcodes
  localparam logic [7:0]  OP_START    = 8'h01;
  localparam logic [7:0]  OP_STOP     = 8'h02;
  localparam logic [7:0]  OP_MLOW     = 8'h03;
  localparam logic [7:0]  OP_MNOM     = 8'h04;
  localparam logic [7:0]  OP_MHIGH    = 8'h05;
  localparam logic [7:0]  OP_INIT     = 8'h06;

  // Status codes, first error of an access wins
  localparam logic [7:0]  ST_OK       = 8'h00;
  localparam logic [7:0]  ST_BAD_LEN  = 8'h01;
  localparam logic [7:0]  ST_IGNORED  = 8'h02;
  localparam logic [7:0]  ST_READ_ONLY = 8'h03;
  localparam logic [7:0]  ST_SHORT    = 8'h04;
  localparam logic [7:0]  ST_OVERRUN  = 8'h05;
  localparam logic [7:0]  STATUS_RST  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_SLA  = 4'h1,
    ST_AHI  = 4'h3,
    ST_ALO  = 4'h2,
    ST_LEN  = 4'h6,
    ST_OPC  = 4'h7,
    ST_WDAT = 4'h5,
    ST_RDAT = 4'h4,
    ST_SKIP = 4'hC
  } pmc_state_e;

  typedef enum logic [1:0] {
    EV_START = 2'h0,
    EV_STOP  = 2'h1,
    EV_RX    = 2'h2,
    EV_TX    = 2'h3
  } pmc_ev_e;

  typedef enum logic [1:0] {
    W_NONE  = 2'h0,
    W_STORE = 2'h1,
    W_MEAS  = 2'h2
  } pmc_wait_e;

  typedef enum logic [1:0] {
    MRG_LOW     = 2'h0,
    MRG_NOMINAL = 2'h1,
    MRG_HIGH    = 2'h2
  } pmc_margin_e;

  typedef struct packed {
    pmc_state_e  st;
    logic        ev_s1;
    logic        ev_s2;
    logic        ev_seen;
    logic        ack_tgl;
    logic        resp_ack;
    logic [7:0]  resp_byte;
    logic [15:0] addr;
    logic [7:0]  len_cnt;
    logic        len_ok;
    logic        is_cmd;
    logic        first;
    logic        ours;
    logic [7:0]  opcode;
    logic [7:0]  chan;
    logic [7:0]  err;
    logic [7:0]  status;
    pmc_wait_e   wt;
    logic        hi_sel;
    logic        st_wr;
    logic        st_rd;
    logic [15:0] st_addr;
    logic [7:0]  st_wdata;
    logic        mv_req;
    logic [4:0]  mv_rail;
    logic        cmd_start;
    logic        cmd_stop;
    logic        cmd_init;
    logic        cmd_margin;
    pmc_margin_e mlevel;
    logic [7:0]  mchan;
  } pmc_sys_s;

  typedef struct packed {
    logic        rs1;
    logic        rs2;
    logic        ev_tgl;
    pmc_ev_e     ev_kind;
    logic [7:0]  ev_byte;
    logic        ak_s1;
    logic        ak_s2;
    logic        ak_seen;
    logic        pend;
    logic        stretch;
    logic        ack;
    logic [7:0]  tx_byte;
  } pmc_lnk_s;

  localparam pmc_sys_s SYS_RST = '{st: ST_IDLE, wt: W_NONE, mlevel: MRG_NOMINAL, status: STATUS_RST, default: '0};
  localparam pmc_lnk_s LNK_RST = '{ev_kind: EV_START, default: '0};

endpackage : pmc_pkg
